// [src/fdchi_params.svh]
`ifndef FDCHI_PARAMS_SVH
`define FDCHI_PARAMS_SVH
// Software register word indices of the controller's own port.
`define FDCHI_REG_CTRL 4'h0
`define FDCHI_REG_STATUS 4'h1
`define FDCHI_REG_CMD_LEN 4'h2
`define FDCHI_REG_RES_LEN 4'h3
`define FDCHI_REG_XFER_LEN 4'h4
`define FDCHI_REG_LAST_MSR 4'h5
`define FDCHI_REG_BUF_IDX 4'h6
`define FDCHI_REG_BUF_DATA 4'h7
// Control register fields.
`define FDCHI_CTRL_GO 0
`define FDCHI_CTRL_DMA 1
`define FDCHI_CTRL_WRITE 2
`define FDCHI_CTRL_MINI 3
`define FDCHI_CTRL_POLL 4
`define FDCHI_CTRL_RESET 8'h00
// Main status bit positions of the device.
`define FDCHI_MSR_DIR 6
`define FDCHI_MSR_RQM 7
`define FDCHI_MSR_EXEC 5
// Post-access wait, figure in ns, and the cycle count derived from it.
`define FDCHI_WAIT_NS 12000
`define FDCHI_CLK_NS 50
`define FDCHI_WAIT_CYC ((`FDCHI_WAIT_NS + `FDCHI_CLK_NS - 1) / `FDCHI_CLK_NS)
// Longest result phase the device defines.
`define FDCHI_MAX_RES 7
`define FDCHI_BUF_DEPTH 16
`endif

// [src/fdchi_pkg.sv]
package fdchi_pkg;
    // Phase of the command sequence as the host walks it.
    typedef enum logic [3:0] {
        FDCHI_IDLE, FDCHI_CMD_POLL, FDCHI_CMD_WAIT, FDCHI_CMD_WR, FDCHI_EXEC,
        FDCHI_EXEC_XFER, FDCHI_RES_POLL, FDCHI_RES_WAIT, FDCHI_RES_RD, FDCHI_DONE
    } fdchi_state_t;
    // Host bus pins toward the device; select, read, write and acknowledge are active low, a0 and tc active high.
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic a0;
        logic dack_n;
        logic tc;
    } fdchi_bus_t;
endpackage

// [src/fdchi_buf.sv]
`timescale 1ns/10ps
`default_nettype none
// Small byte memory holding command bytes, results and execution data.
module fdchi_buf (
    input wire logic clk_sys_in, // System clock.
    input wire logic we_in, // Write enable.
    input wire logic [3:0] waddr_in, // Write index.
    input wire logic [7:0] wdata_in, // Write byte.
    input wire logic [3:0] raddr_in, // Read index.
    output logic [7:0] rdata_out // Registered read byte.
);
    // Storage array, no reset needed since software fills it first.
    logic [7:0] mem [0:15];
    // Write port.
    always_ff @(posedge clk_sys_in)
    begin
        if (we_in)
        begin
            mem[waddr_in] <= wdata_in;
        end
    end
    // Read port comes out of a register.
    always_ff @(posedge clk_sys_in)
    begin
        rdata_out <= mem[raddr_in];
    end
endmodule
`default_nettype wire

// [src/fdchi_host.sv]
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "fdchi_params.svh"
// Host side engine: runs command, execution and result phases on the device.
module fdchi_host (
    input wire logic clk_sys_in, // System clock, 20 MHz.
    input wire logic rst_n_in, // Asynchronous reset, active low.
    input wire logic [3:0] sw_addr_in, // Software register index.
    input wire logic [7:0] sw_wdata_in, // Software write data.
    input wire logic sw_wr_in, // Software write strobe.
    input wire logic sw_rd_in, // Software read strobe.
    output logic [7:0] sw_rdata_out, // Software read data, next cycle.
    output fdchi_pkg::fdchi_bus_t dev_bus_out, // Device control pins.
    output logic [7:0] dev_d_out, // Data bus toward the device.
    output logic dev_d_oe_out, // High while the host drives the data bus.
    input wire logic [7:0] dev_d_in, // Data bus from the device.
    input wire logic dev_irq_in, // Device interrupt request.
    input wire logic dev_drq_in // Device DMA request.
);
    // ************************************************************
    // Configuration and status registers
    // ************************************************************
    logic [7:0] ctrl; // Mode bits written by software.
    logic [3:0] cmd_len; // Command bytes to send.
    logic [3:0] res_len; // Result bytes to read.
    logic [3:0] xfer_len; // Execution data bytes.
    logic [7:0] last_msr; // Last main status seen.
    logic [3:0] sw_idx; // Software buffer pointer.
    logic busy; // Sequence in progress.
    logic done; // Sequence finished, sticky.
    logic seen_irq; // Termination interrupt seen.
    fdchi_pkg::fdchi_state_t state; // Sequencer state.
    logic [3:0] cnt; // Byte counter in current phase.
    logic [9:0] wait_cnt; // Post-access wait counter.
    logic [1:0] strobe_cnt; // Strobe width counter.
    logic [7:0] buf_rdata; // Buffer read data.
    logic buf_we; // Buffer write enable.
    logic [3:0] buf_waddr; // Buffer write index.
    logic [7:0] buf_wdata; // Buffer write data.
    logic [3:0] buf_raddr; // Buffer read index.
    // Wait count doubles at mini-floppy rates.
    function automatic logic [9:0] wait_limit(input logic mini);
        logic [9:0] base;
        base = 10'(`FDCHI_WAIT_CYC);
        wait_limit = mini ? 10'(base << 1) : base;
    endfunction
    // Result bytes start after command bytes in the buffer.
    function automatic logic [3:0] res_slot(input logic [3:0] len, input logic [3:0] i);
        res_slot = 4'(len + i);
    endfunction
    // Software write side: mode bits and lengths.
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ctrl <= `FDCHI_CTRL_RESET;
            cmd_len <= 4'h1;
            res_len <= 4'h7;
            xfer_len <= 4'h0;
        end
        else if (sw_wr_in)
        begin
            unique case (sw_addr_in)
                `FDCHI_REG_CTRL: ctrl <= sw_wdata_in;
                `FDCHI_REG_CMD_LEN: cmd_len <= sw_wdata_in[3:0];
                `FDCHI_REG_RES_LEN: res_len <= sw_wdata_in[3:0];
                `FDCHI_REG_XFER_LEN: xfer_len <= sw_wdata_in[3:0];
                default: ctrl <= ctrl;
            endcase
        end
        else if (state == fdchi_pkg::FDCHI_IDLE && ctrl[`FDCHI_CTRL_GO])
        begin
            // Go bit is self clearing once the sequence starts.
            ctrl[`FDCHI_CTRL_GO] <= 1'b0;
        end
    end
    // Software buffer pointer auto increments on data access.
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sw_idx <= 4'h0;
        end
        else if (sw_wr_in && sw_addr_in == `FDCHI_REG_BUF_IDX)
        begin
            sw_idx <= sw_wdata_in[3:0];
        end
        else if ((sw_wr_in || sw_rd_in) && sw_addr_in == `FDCHI_REG_BUF_DATA)
        begin
            sw_idx <= 4'(sw_idx + 4'h1);
        end
    end
    // Read mux; buffer data come registered so read one cycle later.
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sw_rdata_out <= 8'h00;
        end
        else if (sw_rd_in)
        begin
            unique case (sw_addr_in)
                `FDCHI_REG_CTRL: sw_rdata_out <= ctrl;
                `FDCHI_REG_STATUS: sw_rdata_out <= {5'h00, seen_irq, done, busy};
                `FDCHI_REG_CMD_LEN: sw_rdata_out <= {4'h0, cmd_len};
                `FDCHI_REG_RES_LEN: sw_rdata_out <= {4'h0, res_len};
                `FDCHI_REG_XFER_LEN: sw_rdata_out <= {4'h0, xfer_len};
                `FDCHI_REG_LAST_MSR: sw_rdata_out <= last_msr;
                `FDCHI_REG_BUF_IDX: sw_rdata_out <= {4'h0, sw_idx};
                `FDCHI_REG_BUF_DATA: sw_rdata_out <= buf_rdata;
                default: sw_rdata_out <= 8'h00;
            endcase
        end
    end
    // ************************************************************
    // Buffer port sharing
    // ************************************************************
    // Software owns the buffer while idle; the engine owns it otherwise.
    always_comb
    begin
        buf_we = 1'b0;
        buf_waddr = sw_idx;
        buf_wdata = sw_wdata_in;
        buf_raddr = sw_idx;
        // Look one word ahead on a data access, so back-to-back reads stay fresh.
        if ((sw_wr_in || sw_rd_in) && sw_addr_in == `FDCHI_REG_BUF_DATA)
        begin
            buf_raddr = 4'(sw_idx + 4'h1);
        end
        else if (sw_wr_in && sw_addr_in == `FDCHI_REG_BUF_IDX)
        begin
            buf_raddr = sw_wdata_in[3:0];
        end
        if (busy)
        begin
            buf_raddr = cnt;
            buf_waddr = (state == fdchi_pkg::FDCHI_RES_RD) ? res_slot(cmd_len, cnt) : cnt;
            buf_wdata = dev_d_in;
            buf_we = (state == fdchi_pkg::FDCHI_RES_RD || (state == fdchi_pkg::FDCHI_EXEC_XFER
                && !ctrl[`FDCHI_CTRL_WRITE])) && strobe_cnt == 2'd2;
        end
        else if (sw_wr_in && sw_addr_in == `FDCHI_REG_BUF_DATA)
        begin
            buf_we = 1'b1;
        end
    end
    fdchi_buf u_buf (
        .clk_sys_in(clk_sys_in),
        .we_in(buf_we),
        .waddr_in(buf_waddr),
        .wdata_in(buf_wdata),
        .raddr_in(buf_raddr),
        .rdata_out(buf_rdata)
    );
    // ************************************************************
    // Phase sequencer
    // ************************************************************
    // Each device access is a three cycle strobe; data is sampled in the last.
    // Execution data share the buffer from index 0, so a read transfer overwrites the
    // command bytes; software must reload them for the next command.
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state <= fdchi_pkg::FDCHI_IDLE;
            cnt <= 4'h0;
            wait_cnt <= 10'h000;
            strobe_cnt <= 2'd0;
            busy <= 1'b0;
            done <= 1'b0;
            seen_irq <= 1'b0;
            last_msr <= 8'h00;
            dev_bus_out <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, a0: 1'b0, dack_n: 1'b1,
                tc: 1'b0};
            dev_d_out <= 8'h00;
            dev_d_oe_out <= 1'b0;
        end
        else
        begin
            unique case (state)
                fdchi_pkg::FDCHI_IDLE:
                begin
                    cnt <= 4'h0;
                    if (sw_rd_in && sw_addr_in == `FDCHI_REG_STATUS)
                    begin
                        done <= 1'b0;
                    end
                    if (ctrl[`FDCHI_CTRL_GO])
                    begin
                        busy <= 1'b1;
                        seen_irq <= 1'b0;
                        state <= fdchi_pkg::FDCHI_CMD_POLL;
                    end
                end
                fdchi_pkg::FDCHI_CMD_POLL, fdchi_pkg::FDCHI_RES_POLL:
                begin
                    // Read main status before every byte of these phases.
                    dev_bus_out.cs_n <= 1'b0;
                    dev_bus_out.a0 <= 1'b0;
                    dev_bus_out.rd_n <= (strobe_cnt == 2'd2);
                    strobe_cnt <= (strobe_cnt == 2'd2) ? 2'd0 : 2'(strobe_cnt + 2'd1);
                    if (strobe_cnt == 2'd2)
                    begin
                        last_msr <= dev_d_in;
                        dev_bus_out.cs_n <= 1'b1;
                        // Poll until the handshake bits allow the transfer.
                        if (dev_d_in[`FDCHI_MSR_RQM])
                        begin
                            if (state == fdchi_pkg::FDCHI_CMD_POLL)
                            begin
                                if (!dev_d_in[`FDCHI_MSR_DIR])
                                begin
                                    state <= fdchi_pkg::FDCHI_CMD_WR;
                                end
                            end
                            else if (dev_d_in[`FDCHI_MSR_DIR])
                            begin
                                state <= fdchi_pkg::FDCHI_RES_RD;
                            end
                        end
                    end
                end
                fdchi_pkg::FDCHI_CMD_WR:
                begin
                    // Command bytes leave in buffer order, code first.
                    dev_bus_out.cs_n <= 1'b0;
                    dev_bus_out.a0 <= 1'b1;
                    dev_d_out <= buf_rdata;
                    dev_d_oe_out <= 1'b1;
                    dev_bus_out.wr_n <= (strobe_cnt == 2'd2) || (strobe_cnt == 2'd0);
                    strobe_cnt <= (strobe_cnt == 2'd2) ? 2'd0 : 2'(strobe_cnt + 2'd1);
                    if (strobe_cnt == 2'd2)
                    begin
                        dev_bus_out.cs_n <= 1'b1;
                        dev_d_oe_out <= 1'b0;
                        wait_cnt <= wait_limit(ctrl[`FDCHI_CTRL_MINI]);
                        cnt <= 4'(cnt + 4'h1);
                        state <= fdchi_pkg::FDCHI_CMD_WAIT;
                    end
                end
                fdchi_pkg::FDCHI_CMD_WAIT, fdchi_pkg::FDCHI_RES_WAIT:
                begin
                    // Hold off status reads after each data access.
                    if (wait_cnt != 10'h000 && !ctrl[`FDCHI_CTRL_POLL])
                    begin
                        wait_cnt <= 10'(wait_cnt - 10'h001);
                    end
                    else if (state == fdchi_pkg::FDCHI_CMD_WAIT)
                    begin
                        // Execution follows the last command byte with no shortcut.
                        state <= (cnt == cmd_len) ? fdchi_pkg::FDCHI_EXEC
                            : fdchi_pkg::FDCHI_CMD_POLL;
                        if (cnt == cmd_len)
                        begin
                            cnt <= 4'h0;
                        end
                    end
                    else
                    begin
                        state <= (cnt == res_len) ? fdchi_pkg::FDCHI_DONE
                            : fdchi_pkg::FDCHI_RES_POLL;
                    end
                end
                fdchi_pkg::FDCHI_EXEC:
                begin
                    // No status pre-read here; requests pace the bytes.
                    dev_bus_out.tc <= 1'b0;
                    if (cnt < xfer_len && ctrl[`FDCHI_CTRL_DMA] && dev_drq_in)
                    begin
                        state <= fdchi_pkg::FDCHI_EXEC_XFER;
                    end
                    else if (cnt < xfer_len && !ctrl[`FDCHI_CTRL_DMA] && dev_irq_in)
                    begin
                        state <= fdchi_pkg::FDCHI_EXEC_XFER;
                    end
                    else if (cnt == xfer_len && (dev_irq_in || xfer_len == 4'h0))
                    begin
                        // Termination interrupt opens the result phase; with no execution data it opens at once.
                        seen_irq <= dev_irq_in;
                        cnt <= 4'h0;
                        state <= fdchi_pkg::FDCHI_RES_POLL;
                    end
                end
                fdchi_pkg::FDCHI_EXEC_XFER:
                begin
                    // DMA cycles use acknowledge; programmed ones use select.
                    dev_bus_out.dack_n <= !ctrl[`FDCHI_CTRL_DMA];
                    dev_bus_out.cs_n <= ctrl[`FDCHI_CTRL_DMA];
                    dev_bus_out.a0 <= 1'b1;
                    dev_d_out <= buf_rdata;
                    dev_d_oe_out <= ctrl[`FDCHI_CTRL_WRITE];
                    dev_bus_out.rd_n <= ctrl[`FDCHI_CTRL_WRITE] || strobe_cnt == 2'd2;
                    dev_bus_out.wr_n <= !ctrl[`FDCHI_CTRL_WRITE] || strobe_cnt != 2'd1;
                    // Terminal count rides with acknowledge on the last byte.
                    dev_bus_out.tc <= ctrl[`FDCHI_CTRL_DMA] && 4'(cnt + 4'h1) == xfer_len;
                    strobe_cnt <= (strobe_cnt == 2'd2) ? 2'd0 : 2'(strobe_cnt + 2'd1);
                    if (strobe_cnt == 2'd2)
                    begin
                        dev_bus_out.dack_n <= 1'b1;
                        dev_bus_out.cs_n <= 1'b1;
                        // Terminal count falls together with acknowledge, never after it.
                        dev_bus_out.tc <= 1'b0;
                        dev_d_oe_out <= 1'b0;
                        cnt <= 4'(cnt + 4'h1);
                        state <= fdchi_pkg::FDCHI_EXEC;
                    end
                end
                fdchi_pkg::FDCHI_RES_RD:
                begin
                    // Result bytes land after the command bytes; the first
                    // read also clears the termination interrupt.
                    dev_bus_out.cs_n <= 1'b0;
                    dev_bus_out.a0 <= 1'b1;
                    dev_bus_out.rd_n <= (strobe_cnt == 2'd2);
                    strobe_cnt <= (strobe_cnt == 2'd2) ? 2'd0 : 2'(strobe_cnt + 2'd1);
                    if (strobe_cnt == 2'd2)
                    begin
                        dev_bus_out.cs_n <= 1'b1;
                        cnt <= 4'(cnt + 4'h1);
                        wait_cnt <= wait_limit(ctrl[`FDCHI_CTRL_MINI]);
                        state <= fdchi_pkg::FDCHI_RES_WAIT;
                    end
                end
                fdchi_pkg::FDCHI_DONE:
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    state <= fdchi_pkg::FDCHI_IDLE;
                end
                default:
                begin
                    state <= fdchi_pkg::FDCHI_IDLE;
                end
            endcase
        end
    end
    // ************************************************************
    // Checks
    // ************************************************************
    // A command write only follows a status read showing the ready pattern.
    cmd_gate_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (state == fdchi_pkg::FDCHI_CMD_WR && $past(state) == fdchi_pkg::FDCHI_CMD_POLL)
        |-> (last_msr[`FDCHI_MSR_RQM] && !last_msr[`FDCHI_MSR_DIR]))
        else $error("command written without ready status");
    res_gate_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (state == fdchi_pkg::FDCHI_RES_RD && $past(state) == fdchi_pkg::FDCHI_RES_POLL)
        |-> (last_msr[`FDCHI_MSR_RQM] && last_msr[`FDCHI_MSR_DIR]))
        else $error("result read without ready status");
    wait_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (state == fdchi_pkg::FDCHI_CMD_WAIT && wait_cnt > 10'h001 && !ctrl[`FDCHI_CTRL_POLL])
        |=> state == fdchi_pkg::FDCHI_CMD_WAIT)
        else $error("status read before the wait ended");
    dma_strobe_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (!dev_bus_out.rd_n || !dev_bus_out.wr_n) |-> (!dev_bus_out.dack_n || !dev_bus_out.cs_n))
        else $error("strobe without select or acknowledge");
    tc_qual_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        dev_bus_out.tc |-> !dev_bus_out.dack_n)
        else $error("terminal count without acknowledge");
    no_collide_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        !(!dev_bus_out.rd_n && dev_d_oe_out))
        else $error("host drives bus during read");
    res_count_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        state == fdchi_pkg::FDCHI_DONE |-> $past(cnt) == res_len)
        else $error("command ended before all results read");
    cmd_count_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        ($past(state) == fdchi_pkg::FDCHI_CMD_WAIT && state == fdchi_pkg::FDCHI_EXEC)
        |-> $past(cnt) == cmd_len)
        else $error("execution entered with command short");
    cover_cmd_c: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        state == fdchi_pkg::FDCHI_CMD_WR ##1 state == fdchi_pkg::FDCHI_CMD_WR);
    cover_dma_c: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        !dev_bus_out.dack_n && dev_bus_out.tc);
    cover_done_c: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        state == fdchi_pkg::FDCHI_DONE);
endmodule
`default_nettype wire

// [tb/fdchi_dev_model.sv]
`timescale 1ns/10ps
`default_nettype none
// Disk controller as its host sees it: command, execution and result phases.
module fdchi_dev_model #(parameter int DLY = 8) (
    input wire logic clk_sys_in, // Clock.
    input wire logic rst_n_in, // Reset, active low.
    input wire logic dma_in, // DMA mode.
    input wire fdchi_pkg::fdchi_bus_t bus_in, // Host pins.
    input wire logic [7:0] d_in, // Host data.
    output logic [7:0] d_out, // Device data.
    output logic irq_out, // Interrupt.
    output logic drq_out // DMA request.
);
    logic [1:0] ph; // Phase: 0 command, 1 execution, 2 result.
    logic [3:0] n, busy; // Bytes in this phase, cycles until ready.
    logic [7:0] err, lw, q, qh; // Faults, last write, byte offered, byte held.
    logic rd_q, wr_q, hold, sel, acc, ok;
    assign sel = !bus_in.cs_n || !bus_in.dack_n;
    // Status byte anytime; execution reuses the request bit as byte ready.
    assign q = (!bus_in.a0 && bus_in.dack_n) ?
        {ph == 2'd1 ? irq_out | drq_out : busy == 4'h0, ph == 2'd2, ph == 2'd1, 5'h00} :
        (ph == 2'd2 ? 8'hA0 : 8'h50) + {4'h0, n};
    // A released bus shows the inverse, so a stale byte never looks valid.
    assign d_out = hold ? qh : ~qh;
    assign acc = sel && (bus_in.a0 || !bus_in.dack_n) &&
        ((rd_q && !bus_in.rd_n) || (wr_q && !bus_in.wr_n));
    assign ok = busy == 4'h0 && (ph == 2'd0 ? !bus_in.wr_n :
        ph == 2'd2 ? !bus_in.rd_n : dma_in != bus_in.dack_n);
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            {ph, n, busy, err, lw, qh, irq_out, drq_out, hold} <= '0;
            {rd_q, wr_q} <= 2'b11;
        end
        else
        begin
            rd_q <= bus_in.rd_n;
            wr_q <= bus_in.wr_n;
            hold <= sel && (hold || !bus_in.rd_n);
            if (sel && rd_q && !bus_in.rd_n)
                qh <= q;
            if (busy != 4'h0)
                busy <= busy - 4'h1;
            if (busy == 4'h1 && ph == 2'd1)
            begin
                drq_out <= dma_in;
                irq_out <= !dma_in;
            end
            if (!bus_in.dack_n)
                drq_out <= 1'b0;
            if (acc)
            begin
                err <= err + {7'h00, !ok};
                busy <= DLY[3:0];
                n <= n + 4'h1;
                irq_out <= 1'b0;
                if (!bus_in.wr_n)
                    lw <= d_in;
                if (ph == 2'd1 && (n == 4'h1 || (bus_in.tc && !bus_in.dack_n)))
                begin
                    ph <= 2'd2;
                    n <= 4'h0;
                    irq_out <= 1'b1;
                end
                else if (ph != 2'd1 && n == (ph == 2'd0 ? 4'h2 : 4'h6))
                begin
                    ph <= {1'b0, ph == 2'd0};
                    n <= 4'h0;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/10ps
`default_nettype none
// Host engine driven through its register port against the device model.
module tb;
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic sw_wr_in = 1'b0;
    logic sw_rd_in = 1'b0;
    logic dma = 1'b0;
    logic [3:0] sw_addr_in = 4'h0;
    logic [7:0] sw_wdata_in = 8'h00;
    logic [7:0] sw_rdata_out, dev_d_out, dev_d_in, rv;
    logic dev_d_oe_out, dev_irq_in, dev_drq_in;
    fdchi_pkg::fdchi_bus_t dev_bus_out;
    int fail_count = 0;
    int comparisons = 0;
    int now = 0;
    fdchi_host i_dut (.clk_sys_in, .rst_n_in, .sw_addr_in, .sw_wdata_in, .sw_wr_in, .sw_rd_in,
        .sw_rdata_out, .dev_bus_out, .dev_d_out, .dev_d_oe_out, .dev_d_in, .dev_irq_in,
        .dev_drq_in);
    fdchi_dev_model i_dev (.clk_sys_in, .rst_n_in, .dma_in(dma), .bus_in(dev_bus_out),
        .d_in(dev_d_out), .d_out(dev_d_in), .irq_out(dev_irq_in), .drq_out(dev_drq_in));
    initial
    begin
        forever #25 clk_sys_in = ~clk_sys_in;
    end
    always @(posedge clk_sys_in)
        now++;
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    begin
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    end
    endtask
    // A strobe gap after each access keeps one assignment per signal and time step.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
    begin
        sw_addr_in <= a;
        sw_wdata_in <= d;
        sw_wr_in <= 1'b1;
        @(posedge clk_sys_in);
        sw_wr_in <= 1'b0;
        @(posedge clk_sys_in);
    end
    endtask
    task automatic rd(input logic [3:0] a);
    begin
        sw_addr_in <= a;
        sw_rd_in <= 1'b1;
        @(posedge clk_sys_in);
        sw_rd_in <= 1'b0;
        #1 rv = sw_rdata_out;
        @(posedge clk_sys_in);
    end
    endtask
    task automatic tally_and_finish;
    begin
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
    endtask
    // Three command bytes, two data bytes, seven results; cyc returns the run time.
    task automatic run(input logic [7:0] ctrl, output int cyc);
        int i;
    begin
        dma <= ctrl[1];
        wr(4'h6, 8'h00);
        for (i = 0; i < 3; i++)
            wr(4'h7, 8'h10 + i[7:0]);
        wr(4'h2, 8'h03);
        wr(4'h3, 8'h07);
        wr(4'h4, 8'h02);
        wr(4'h0, ctrl);
        cyc = now;
        rv = 8'h00;
        for (i = 0; i < 20000 && rv[1] !== 1'b1; i++)
            rd(4'h1);
        if (rv[1] !== 1'b1)
        begin
            fail_count++;
            tally_and_finish;
        end
        cyc = now - cyc;
        chk("faults", i_dev.err, 8'h00);
        chk("phase", {6'h00, i_dev.ph}, 8'h00);
        wr(4'h6, 8'h03);
        for (i = 0; i < 7; i++)
        begin
            rd(4'h7);
            chk("result", rv, 8'hA0 + i[7:0]);
        end
    end
    endtask
    task automatic t_reset;
    begin
        chk("pins", {2'b00, dev_bus_out}, 8'h3A);
        rd(4'h2);
        chk("cmd len", rv, 8'h01);
        rd(4'h3);
        chk("res len", rv, 8'h07);
        $display("test reset done");
    end
    endtask
    task automatic t_prog_read;
        int c;
    begin
        run(8'h11, c);
        wr(4'h6, 8'h00);
        rd(4'h7);
        chk("data 0", rv, 8'h50);
        rd(4'h7);
        chk("data 1", rv, 8'h51);
        $display("test programmed read done");
    end
    endtask
    task automatic t_dma_write;
        int c;
    begin
        run(8'h17, c);
        chk("written", i_dev.lw, 8'h11);
        run(8'h13, c);
        run(8'h15, c);
        chk("prog written", i_dev.lw, 8'h11);
        $display("test dma done");
    end
    endtask
    task automatic t_mini_wait;
        int c;
    begin
        run(8'h09, c);
        chk("mini wait", {7'h00, c >= 4800}, 8'h01);
        $display("test wait done");
    end
    endtask
    initial
    begin
        repeat (2) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        @(posedge clk_sys_in);
        t_reset;
        t_prog_read;
        t_dma_write;
        t_mini_wait;
        tally_and_finish;
    end
endmodule
`default_nettype wire
